// >>> core/mmuw_pkg.sv
// shared constants and types of the table-walk translation block
package mmuw_pkg;
    // register byte offsets on the AHB-Lite slave
    localparam logic [7:0]  MMUW_ROOT_OFS   = 8'h00; // table_root_register
    localparam logic [7:0]  MMUW_CTRL_OFS   = 8'h04; // processor_status_word copy
    localparam logic [7:0]  MMUW_STAT_OFS   = 8'h08; // walker state, read only
    localparam logic [7:0]  MMUW_FADDR_OFS  = 8'h0C; // last faulting virtual address
    // reset values
    localparam logic [31:0] MMUW_ROOT_RST   = 32'h0000_0000;
    localparam logic        MMUW_XLATE_RST  = 1'b0;
    // control and status field positions
    localparam int          MMUW_CTRL_XLATE = 0;  // translate_enable_bit
    localparam int          MMUW_STAT_BUSY  = 0;
    localparam int          MMUW_STAT_FLT   = 1;
    localparam int          MMUW_STAT_WFLT  = 2;
    // table entry field positions
    localparam int          MMUW_ENT_VALID  = 0;
    localparam int          MMUW_ENT_WRITE  = 1;
    localparam int          MMUW_ENT_USER   = 2;
    localparam int          MMUW_ENT_SEGTY  = 3;  // segment entries: 1 = flat segment
    localparam int          MMUW_ENT_REF    = 3;  // leaf_mapping_entry referenced
    localparam int          MMUW_ENT_MOD    = 4;  // leaf_mapping_entry modified
    localparam int          MMUW_ENT_CACHE  = 11;
    localparam int          MMUW_BASE_LO    = 12; // page aligned table and frame bases
    localparam int          MMUW_FLAT_LO    = 22; // flat segment base and segment number
    localparam int          MMUW_TBL_ENTRIES = 1024; // entries per 4 KB table, 4 bytes each
    // walker states
    typedef enum logic [2:0] {
        MMUW_ST_IDLE,
        MMUW_ST_SEG,
        MMUW_ST_PTE,
        MMUW_ST_WB
    } mmuw_state_t;
endpackage

// >>> core/mmuw_walker.sv
// table-walk address translation and protection unit with AHB-Lite registers
// Behaviour
// R1 - segment entry address is root bits 31:12 above virtual address bits 31:22
// R2 - segment table is one 4 KB frame of 1,024 four-byte entries
// R3 - segment entry bit 3 picks paged (0) or flat base-and-bound (1) translation
// R4 - each segment entry decoded alone, so tables may mix both kinds
// R5 - paged segment entry: bits 31:12 page table base, bit 0 valid
// R6 - paged segment bit 11 set keeps no-cache strobe off during leaf fetch
// R7 - paged segments have no length; only leaf validity bounds them
// R8 - flat segment size is bits 21:12 in 4 KB steps, 0 meaning 4 KB
// R9 - flat physical address is entry bits 31:22 above the segment offset
// R10 - flat entry bit 2 allows user, bit 1 allows writes
// R11 - final bit 11 clear asserts no-cache strobe, set deasserts it
// R12 - protection violation issues no memory access and signals a memory fault
// R13 - leaf entry address is segment entry bits 31:12 above page number
// R14 - paged physical address is leaf bits 31:12 above the page offset
// R15 - modified bit set on first write, not rewritten once set
// R16 - referenced bit set on first reference, not rewritten once set
// R17 - hardware only sets referenced and modified bits, software clears them
// R18 - leaf bit 0 valid, bit 2 user, bit 1 writable
// R19 - software editing leaf status bits must invalidate cached copies itself
// R20 - translation only while translate enable is set, else address passes through
// R21 - bus lock held over leaf fetch and any status write-back
// R22 - write to unmapped, kernel-only or read-only page raises write fault
// R23 - flat offset past the bound faults; reserved entry bits are ignored
//
// The address map and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module mmuw_walker
    import mmuw_pkg::*;
(
    input  wire logic        core_clk,        // processor clock, 100 MHz
    input  wire logic        rst_n,           // synchronous reset, active low
    input  wire logic        hsel,            // ahb slave select
    input  wire logic [31:0] haddr,           // ahb address
    input  wire logic [1:0]  htrans,          // ahb transfer type
    input  wire logic        hwrite,          // ahb write
    input  wire logic [2:0]  hsize,           // ahb size, word only
    input  wire logic [31:0] hwdata,          // ahb write data
    input  wire logic        hready,          // ahb bus ready
    output logic      [31:0] hrdata,          // ahb read data
    output logic             hreadyout,       // ahb slave ready
    output logic             hresp,           // ahb response, always okay
    input  wire logic        req_valid,       // translation request
    input  wire logic [31:0] req_vaddr,       // virtual address
    input  wire logic        req_write,       // write or stack operation
    input  wire logic        req_user,        // user execution level
    output logic             req_ready,       // walker can take a request
    output logic             rsp_valid,       // one-cycle answer pulse
    output logic      [31:0] rsp_paddr,       // physical address
    output logic             rsp_fault,       // memory fault, no access made
    output logic             rsp_write_fault, // fault was on a write
    output logic             rsp_no_cache_n,  // no_cache_strobe for the access, low = no cache
    output logic             mem_req,         // table memory request, held until ack
    output logic      [31:0] mem_addr,        // table word address
    output logic             mem_write,       // table write-back
    output logic      [31:0] mem_wdata,       // table write data
    input  wire logic [31:0] mem_rdata,       // table read data, valid with ack
    input  wire logic        mem_ack,         // table access done
    output logic             mem_lock_n,      // bus lock, active low
    output logic             mem_no_cache_n   // no_cache_strobe for table fetch, low = no cache
);

    // segment entry word: frame from the root, word index from the segment number
    function automatic logic [31:0] seg_entry_addr(input logic [31:0] root,
                                                    input logic [31:0] va);
        seg_entry_addr = {root[31:MMUW_BASE_LO], va[31:MMUW_FLAT_LO], 2'b00};
    endfunction

    // leaf entry word: page table frame from the segment entry, index from page number
    function automatic logic [31:0] leaf_entry_addr(input logic [31:0] seg,
                                                     input logic [31:0] va);
        leaf_entry_addr = {seg[31:MMUW_BASE_LO], va[21:MMUW_BASE_LO], 2'b00};
    endfunction

    // valid, user and write checks shared by flat segments and leaf entries
    function automatic logic perm_ok(input logic [31:0] ent, input logic user,
                                     input logic wr);
        perm_ok = ent[MMUW_ENT_VALID] && (!user || ent[MMUW_ENT_USER])
                  && (!wr || ent[MMUW_ENT_WRITE]);
    endfunction

    // ---------------- register slave state ----------------
    logic [31:0] root_r, root_nxt;
    logic        xlate_r, xlate_nxt;
    logic        wpend_r, wpend_nxt;
    logic [7:0]  waddr_r, waddr_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic        hreadyout_r;

    // ---------------- walker state ----------------
    mmuw_state_t st_r, st_nxt;
    logic [31:0] vaddr_r, vaddr_nxt;
    logic        wr_r, wr_nxt;
    logic        user_r, user_nxt;
    logic [31:0] seg_r, seg_nxt;
    logic [31:0] pte_r, pte_nxt;
    logic        ready_r, ready_nxt;
    logic        rsp_valid_r, rsp_valid_nxt;
    logic [31:0] rsp_paddr_r, rsp_paddr_nxt;
    logic        rsp_fault_r, rsp_fault_nxt;
    logic        rsp_wfault_r, rsp_wfault_nxt;
    logic        rsp_ncn_r, rsp_ncn_nxt;
    logic        mreq_r, mreq_nxt;
    logic [31:0] maddr_r, maddr_nxt;
    logic        mwr_r, mwr_nxt;
    logic [31:0] mwdata_r, mwdata_nxt;
    logic        lock_n_r, lock_n_nxt;
    logic        mncn_r, mncn_nxt;
    logic        lastflt_r, lastflt_nxt;
    logic        lastwflt_r, lastwflt_nxt;
    logic [31:0] faddr_r, faddr_nxt;

    // register read mux; an unmapped offset reads zero
    function automatic logic [31:0] reg_read(input logic [7:0] ofs);
        reg_read = 32'h0000_0000;
        if (ofs == MMUW_ROOT_OFS) begin
            reg_read = {root_r[31:MMUW_BASE_LO], 12'h000};
        end else if (ofs == MMUW_CTRL_OFS) begin
            reg_read[MMUW_CTRL_XLATE] = xlate_r;
        end else if (ofs == MMUW_STAT_OFS) begin
            reg_read[MMUW_STAT_BUSY] = (st_r != MMUW_ST_IDLE);
            reg_read[MMUW_STAT_FLT]  = lastflt_r;
            reg_read[MMUW_STAT_WFLT] = lastwflt_r;
        end else if (ofs == MMUW_FADDR_OFS) begin
            reg_read = faddr_r;
        end
    endfunction

    // zero-wait slave: address phase captured, write lands in the data phase
    always_comb begin
        root_nxt   = root_r;
        xlate_nxt  = xlate_r;
        wpend_nxt  = 1'b0;
        waddr_nxt  = waddr_r;
        hrdata_nxt = hrdata_r;
        if (wpend_r) begin
            if (waddr_r == MMUW_ROOT_OFS) begin
                root_nxt = {hwdata[31:MMUW_BASE_LO], 12'h000};
            end else if (waddr_r == MMUW_CTRL_OFS) begin
                xlate_nxt = hwdata[MMUW_CTRL_XLATE];
            end
        end
        if (hsel && htrans[1] && hready) begin
            if (hwrite) begin
                wpend_nxt = 1'b1;
                waddr_nxt = haddr[7:0];
            end else if (wpend_r && waddr_r == haddr[7:0]
                         && (waddr_r == MMUW_ROOT_OFS || waddr_r == MMUW_CTRL_OFS)) begin
                // forward a write still in its data phase so a read right behind sees it
                hrdata_nxt = (waddr_r == MMUW_ROOT_OFS) ?
                             {hwdata[31:MMUW_BASE_LO], 12'h000} :
                             {31'h0000_0000, hwdata[MMUW_CTRL_XLATE]};
            end else begin
                hrdata_nxt = reg_read(haddr[7:0]);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            root_r      <= MMUW_ROOT_RST;
            xlate_r     <= MMUW_XLATE_RST;
            wpend_r     <= 1'b0;
            waddr_r     <= 8'h00;
            hrdata_r    <= 32'h0000_0000;
            hreadyout_r <= 1'b1;
        end else begin
            root_r      <= root_nxt;
            xlate_r     <= xlate_nxt;
            wpend_r     <= wpend_nxt;
            waddr_r     <= waddr_nxt;
            hrdata_r    <= hrdata_nxt;
            hreadyout_r <= 1'b1;
        end
    end

    // walker next state; done/fault collect the answer from every branch
    always_comb begin
        logic        done;
        logic        flt;
        logic [31:0] pa;
        logic        ncn;
        logic [31:0] upd;
        done = 1'b0;
        flt  = 1'b0;
        pa   = 32'h0000_0000;
        ncn  = 1'b1;
        upd  = 32'h0000_0000;
        st_nxt        = st_r;
        vaddr_nxt     = vaddr_r;
        wr_nxt        = wr_r;
        user_nxt      = user_r;
        seg_nxt       = seg_r;
        pte_nxt       = pte_r;
        ready_nxt     = ready_r;
        rsp_valid_nxt = 1'b0;
        rsp_paddr_nxt = rsp_paddr_r;
        rsp_fault_nxt = rsp_fault_r;
        rsp_wfault_nxt = rsp_wfault_r;
        rsp_ncn_nxt   = rsp_ncn_r;
        mreq_nxt      = mreq_r;
        maddr_nxt     = maddr_r;
        mwr_nxt       = mwr_r;
        mwdata_nxt    = mwdata_r;
        lock_n_nxt    = lock_n_r;
        mncn_nxt      = mncn_r;
        lastflt_nxt   = lastflt_r;
        lastwflt_nxt  = lastwflt_r;
        faddr_nxt     = faddr_r;
        case (st_r)
            MMUW_ST_IDLE: begin
                if (req_valid && ready_r) begin
                    vaddr_nxt = req_vaddr;
                    wr_nxt    = req_write;
                    user_nxt  = req_user;
                    if (!xlate_r) begin
                        done = 1'b1; // R20
                        pa   = req_vaddr;
                    end else begin
                        st_nxt     = MMUW_ST_SEG;
                        ready_nxt  = 1'b0;
                        mreq_nxt   = 1'b1;
                        mwr_nxt    = 1'b0;
                        maddr_nxt  = seg_entry_addr(root_r, req_vaddr); // R1 R2
                        mncn_nxt   = 1'b1;
                    end
                end
            end
            MMUW_ST_SEG: begin
                if (mem_ack) begin
                    mreq_nxt = 1'b0;
                    seg_nxt  = mem_rdata;
                    if (mem_rdata[MMUW_ENT_SEGTY]) begin // R3 R4
                        // flat segment: bound and permissions, reserved bits never looked at
                        done = 1'b1;
                        flt  = !perm_ok(mem_rdata, user_r, wr_r) // R10 R22
                               || (vaddr_r[21:MMUW_BASE_LO] > mem_rdata[21:MMUW_BASE_LO]); // R8 R23
                        pa   = {mem_rdata[31:MMUW_FLAT_LO], vaddr_r[MMUW_FLAT_LO-1:0]}; // R9
                        ncn  = mem_rdata[MMUW_ENT_CACHE]; // R11
                    end else if (!mem_rdata[MMUW_ENT_VALID]) begin
                        done = 1'b1; // R5 R12
                        flt  = 1'b1;
                    end else begin
                        // paged: no extent check, only the leaf entry decides (R7)
                        st_nxt     = MMUW_ST_PTE;
                        mreq_nxt   = 1'b1;
                        maddr_nxt  = leaf_entry_addr(mem_rdata, vaddr_r); // R5 R13
                        lock_n_nxt = 1'b0; // R21
                        mncn_nxt   = mem_rdata[MMUW_ENT_CACHE]; // R6
                    end
                end
            end
            MMUW_ST_PTE: begin
                if (mem_ack) begin
                    mreq_nxt = 1'b0;
                    pte_nxt  = mem_rdata;
                    upd      = mem_rdata;
                    upd[MMUW_ENT_REF] = 1'b1; // R16 R17
                    upd[MMUW_ENT_MOD] = mem_rdata[MMUW_ENT_MOD] | wr_r; // R15 R17
                    pa  = {mem_rdata[31:MMUW_BASE_LO], vaddr_r[MMUW_BASE_LO-1:0]}; // R14
                    ncn = mem_rdata[MMUW_ENT_CACHE]; // R11
                    if (!perm_ok(mem_rdata, user_r, wr_r)) begin
                        done = 1'b1; // R18 R22 R12
                        flt  = 1'b1;
                    end else if (upd != mem_rdata) begin
                        // status bits stale: write back under the same lock
                        st_nxt     = MMUW_ST_WB; // R21
                        mreq_nxt   = 1'b1;
                        mwr_nxt    = 1'b1;
                        mwdata_nxt = upd;
                        pte_nxt    = upd;
                    end else begin
                        done = 1'b1; // R15 R16
                    end
                end
            end
            MMUW_ST_WB: begin
                if (mem_ack) begin
                    mreq_nxt = 1'b0;
                    mwr_nxt  = 1'b0;
                    done     = 1'b1;
                    pa  = {pte_r[31:MMUW_BASE_LO], vaddr_r[MMUW_BASE_LO-1:0]}; // R14
                    ncn = pte_r[MMUW_ENT_CACHE];
                end
            end
            default: begin
                st_nxt = MMUW_ST_IDLE;
            end
        endcase
        // common answer: lock dropped, no access follows a fault
        if (done) begin
            st_nxt         = MMUW_ST_IDLE;
            ready_nxt      = 1'b1;
            lock_n_nxt     = 1'b1; // R21
            mncn_nxt       = 1'b1;
            rsp_valid_nxt  = 1'b1;
            rsp_fault_nxt  = flt; // R12
            rsp_wfault_nxt = flt && (st_r == MMUW_ST_IDLE ? req_write : wr_r); // R22
            rsp_paddr_nxt  = flt ? 32'h0000_0000 : pa;
            rsp_ncn_nxt    = flt ? 1'b1 : ncn;
            lastflt_nxt    = flt;
            lastwflt_nxt   = flt && wr_r;
            if (flt) begin
                faddr_nxt = vaddr_r;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_r         <= MMUW_ST_IDLE;
            vaddr_r      <= 32'h0000_0000;
            wr_r         <= 1'b0;
            user_r       <= 1'b0;
            seg_r        <= 32'h0000_0000;
            pte_r        <= 32'h0000_0000;
            ready_r      <= 1'b1;
            rsp_valid_r  <= 1'b0;
            rsp_paddr_r  <= 32'h0000_0000;
            rsp_fault_r  <= 1'b0;
            rsp_wfault_r <= 1'b0;
            rsp_ncn_r    <= 1'b1;
            mreq_r       <= 1'b0;
            maddr_r      <= 32'h0000_0000;
            mwr_r        <= 1'b0;
            mwdata_r     <= 32'h0000_0000;
            lock_n_r     <= 1'b1;
            mncn_r       <= 1'b1;
            lastflt_r    <= 1'b0;
            lastwflt_r   <= 1'b0;
            faddr_r      <= 32'h0000_0000;
        end else begin
            st_r         <= st_nxt;
            vaddr_r      <= vaddr_nxt;
            wr_r         <= wr_nxt;
            user_r       <= user_nxt;
            seg_r        <= seg_nxt;
            pte_r        <= pte_nxt;
            ready_r      <= ready_nxt;
            rsp_valid_r  <= rsp_valid_nxt;
            rsp_paddr_r  <= rsp_paddr_nxt;
            rsp_fault_r  <= rsp_fault_nxt;
            rsp_wfault_r <= rsp_wfault_nxt;
            rsp_ncn_r    <= rsp_ncn_nxt;
            mreq_r       <= mreq_nxt;
            maddr_r      <= maddr_nxt;
            mwr_r        <= mwr_nxt;
            mwdata_r     <= mwdata_nxt;
            lock_n_r     <= lock_n_nxt;
            mncn_r       <= mncn_nxt;
            lastflt_r    <= lastflt_nxt;
            lastwflt_r   <= lastwflt_nxt;
            faddr_r      <= faddr_nxt;
        end
    end

    // every output straight from a flop, except hresp, which is tied low
    assign hrdata          = hrdata_r;
    assign hreadyout       = hreadyout_r;
    assign hresp           = 1'b0;
    assign req_ready       = ready_r;
    assign rsp_valid       = rsp_valid_r;
    assign rsp_paddr       = rsp_paddr_r;
    assign rsp_fault       = rsp_fault_r;
    assign rsp_write_fault = rsp_wfault_r;
    assign rsp_no_cache_n  = rsp_ncn_r;
    assign mem_req         = mreq_r;
    assign mem_addr        = maddr_r;
    assign mem_write       = mwr_r;
    assign mem_wdata       = mwdata_r;
    assign mem_lock_n      = lock_n_r;
    assign mem_no_cache_n  = mncn_r;

    // leaf word as read, kept for the write-back checks; the memory scrambles its bus later
    logic [31:0] mem_rdata_hold;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mem_rdata_hold <= 32'h0000_0000;
        end else if (st_r == MMUW_ST_PTE && mem_ack) begin
            mem_rdata_hold <= mem_rdata;
        end
    end

    // checks on the walk
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence seg_ack_s;
        st_r == MMUW_ST_SEG && mem_ack;
    endsequence
    sequence flat_hit_s;
        seg_ack_s ##0 mem_rdata[MMUW_ENT_SEGTY] && perm_ok(mem_rdata, user_r, wr_r)
        && vaddr_r[21:12] <= mem_rdata[21:12];
    endsequence
    sequence leaf_current_s;
        st_r == MMUW_ST_PTE && mem_ack && perm_ok(mem_rdata, user_r, wr_r)
        && mem_rdata[MMUW_ENT_REF] && (!wr_r || mem_rdata[MMUW_ENT_MOD]);
    endsequence

    seg_addr_a: assert property (st_r == MMUW_ST_SEG && mem_req |-> // R1
        mem_addr == {root_r[31:12], vaddr_r[31:22], 2'b00})
        else $error("segment entry address wrong");
    leaf_addr_a: assert property (st_r == MMUW_ST_PTE && mem_req |-> // R13
        mem_addr == {seg_r[31:12], vaddr_r[21:12], 2'b00})
        else $error("leaf entry address wrong");
    flat_addr_a: assert property (flat_hit_s |=> rsp_valid && !rsp_fault // R9
        && rsp_paddr == {$past(mem_rdata[31:22]), vaddr_r[21:0]}
        && rsp_no_cache_n == $past(mem_rdata[11]))
        else $error("flat segment answer wrong");
    flat_bound_a: assert property (seg_ack_s ##0 mem_rdata[3] && mem_rdata[0] // R23
        && vaddr_r[21:12] > mem_rdata[21:12] |=> rsp_valid && rsp_fault)
        else $error("bound overrun not faulted");
    leaf_skip_a: assert property (leaf_current_s |=> rsp_valid && !rsp_fault // R14
        && !mem_req && rsp_paddr == {$past(mem_rdata[31:12]), vaddr_r[11:0]})
        else $error("current leaf answer wrong");
    fault_quiet_a: assert property (rsp_valid && rsp_fault |-> !mem_req && !mem_write // R12
        && mem_lock_n)
        else $error("memory access after fault");
    lock_hold_a: assert property ((st_r == MMUW_ST_PTE || st_r == MMUW_ST_WB) |-> // R21
        !mem_lock_n)
        else $error("lock dropped during leaf walk");
    leaf_nocache_a: assert property (st_r == MMUW_ST_PTE |-> mem_no_cache_n == seg_r[11]) // R6
        else $error("no-cache strobe wrong on leaf fetch");
    wb_bits_a: assert property (mem_write |-> mem_wdata[3] // R15
        && mem_wdata[4] == (wr_r || mem_rdata_hold[4]))
        else $error("write-back status bits wrong");
    set_only_a: assert property (mem_write |-> (mem_wdata | mem_rdata_hold) == mem_wdata) // R17
        else $error("write-back cleared a bit");
    pass_thru_a: assert property (st_r == MMUW_ST_IDLE && req_valid && req_ready // R20
        && !xlate_r |=> rsp_valid && !rsp_fault && rsp_paddr == $past(req_vaddr))
        else $error("pass-through address wrong");

endmodule

// >>> tb/mmuw_mem.sv
// table memory partner holding segment and leaf entries
`timescale 1ns/1ps
module mmuw_mem (
    input  wire logic        core_clk,  // processor clock
    input  wire logic        mem_req,   // table request
    input  wire logic [31:0] mem_addr,  // byte address of word
    input  wire logic        mem_write, // write-back
    input  wire logic [31:0] mem_wdata, // write data
    output logic      [31:0] mem_rdata = 32'h0, // data in ack cycle
    output logic             mem_ack = 1'b0,    // one-cycle done
    input  wire logic [3:0]  delay      // wait cycles before ack
);
    logic [31:0] m [logic [31:0]];
    int          cnt = 0;
    // data is inverted outside the ack so a stale read is never trusted
    always @(posedge core_clk) begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_req && !mem_ack) begin
            cnt = cnt + 1;
            if (cnt > delay) begin
                cnt = 0;
                mem_ack <= 1'b1;
                mem_rdata <= m[mem_addr];
                if (mem_write) m[mem_addr] = mem_wdata;
            end
        end
    end
endmodule

// >>> tb/mmuw_walker_bench.sv
// self-checking bench for the table-walk translation unit
`timescale 1ns/1ps
module mmuw_walker_bench;
    import mmuw_pkg::*;
    logic        core_clk = 0, rst_n = 0, hsel = 0, hwrite = 0, xon = 0;
    logic        req_valid = 0, req_write = 0, req_user = 0, hreadyout, hresp, req_ready;
    logic        rsp_valid, rsp_fault, rsp_write_fault, rsp_no_cache_n;
    logic        mem_req, mem_write, mem_ack, mem_lock_n, mem_no_cache_n;
    logic [31:0] haddr = 0, hwdata = 0, req_vaddr = 0, root = 0, q;
    logic [31:0] hrdata, rsp_paddr, mem_addr, mem_wdata, mem_rdata;
    logic [1:0]  htrans = 0;
    logic [3:0]  delay = 0;
    int          num_errors = 0, checks = 0;
    logic [15:0] cases [13] = '{16'h1003, 16'h1011, 16'h100E, 16'h2FFD, 16'h2002, 16'h2FFC,
                                16'h3001, 16'h3003, 16'h3003, 16'h3006, 16'h3004, 16'h3008, 16'h4000};
    always #5 core_clk = ~core_clk;
    mmuw_walker mmuw_walker_inst (.core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .req_valid,
        .req_vaddr, .req_write, .req_user, .req_ready, .rsp_valid, .rsp_paddr, .rsp_fault,
        .rsp_write_fault, .rsp_no_cache_n, .mem_req, .mem_addr, .mem_write, .mem_wdata,
        .mem_rdata, .mem_ack, .mem_lock_n, .mem_no_cache_n);
    mmuw_mem mmuw_mem_inst (.core_clk, .mem_req, .mem_addr, .mem_write, .mem_wdata,
        .mem_rdata, .mem_ack, .delay);
    task automatic give_verdict;
        if (num_errors == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    // single word transfer; read data is taken at the data-phase end edge
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    // reference walk from the in-memory tables, then one request and its answer
    task automatic xlate(input logic [31:0] va, input logic wr, input logic us);
        logic [31:0] s, p, ea, pa;
        logic        f, nc;
        f = 1'b0;
        nc = 1'b1;
        pa = va;
        s = mmuw_mem_inst.m[{root[31:12], va[31:22], 2'b00}];
        ea = {s[31:12], va[21:12], 2'b00};
        p = s[3] ? s : mmuw_mem_inst.m[ea];
        if (xon) begin
            f = !s[0] || !p[0] || (us && !p[2]) || (wr && !p[1]) || (s[3] && va[21:12] > s[21:12]);
            pa = f ? 32'h0 : s[3] ? {s[31:22], va[21:0]} : {p[31:12], va[11:0]};
            nc = f || p[11];
        end
        @(posedge core_clk);
        req_valid <= 1'b1;
        req_vaddr <= va;
        req_write <= wr;
        req_user <= us;
        delay <= 4'($urandom_range(0, 5));
        @(posedge core_clk);
        req_valid <= 1'b0;
        #1;
        for (int i = 0; rsp_valid !== 1'b1; i++) begin
            if (i == 300) begin
                num_errors++;
                give_verdict;
            end
            @(posedge core_clk);
            #1;
        end
        cmp("paddr", pa, rsp_paddr);
        cmp("fault", 32'(f), 32'(rsp_fault));
        cmp("write fault", 32'(f && wr), 32'(rsp_write_fault));
        cmp("no cache", 32'(nc), 32'(rsp_no_cache_n));
        if (xon && !f && !s[3]) cmp("leaf", p | 32'h8 | (wr ? 32'h10 : 32'h0), mmuw_mem_inst.m[ea]);
    endtask
    initial begin
        #900000;
        num_errors++;
        give_verdict;
    end
    initial begin
        void'($urandom(73312));
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        ahb(1'b0, MMUW_ROOT_OFS, 32'h0);
        cmp("root", MMUW_ROOT_RST, q);
        ahb(1'b0, MMUW_CTRL_OFS, 32'h0);
        cmp("ctrl", 32'(MMUW_XLATE_RST), q);
        ahb(1'b0, 8'h10, 32'h0);
        cmp("unmapped", 32'h0, q);
        xlate($urandom, 1'b1, 1'b1);
        root = {4'h8, 16'($urandom), 12'h000};
        ahb(1'b1, MMUW_ROOT_OFS, root | 32'hFFF);
        ahb(1'b0, MMUW_ROOT_OFS, 32'h0);
        cmp("root", root, q);
        // flat, flat read-only, paged and invalid segments, reserved bits set in some
        mmuw_mem_inst.m[{root[31:12], 10'h1, 2'b00}] = 32'hB000_37FF;
        mmuw_mem_inst.m[{root[31:12], 10'h2, 2'b00}] = 32'h407F_F809;
        mmuw_mem_inst.m[{root[31:12], 10'h3, 2'b00}] = 32'h0005_0807;
        mmuw_mem_inst.m[{root[31:12], 10'h4, 2'b00}] = 32'h0006_0000;
        mmuw_mem_inst.m[32'h0005_0000] = 32'h1234_5807;
        mmuw_mem_inst.m[32'h0005_0004] = 32'h0ABC_D019;
        mmuw_mem_inst.m[32'h0005_0008] = 32'h0777_7006;
        ahb(1'b1, MMUW_CTRL_OFS, 32'h1);
        xon = 1'b1;
        foreach (cases[i]) xlate({6'h0, cases[i][15:12], cases[i][11:2], 12'($urandom)}, cases[i][1], cases[i][0]);
        give_verdict;
    end
endmodule
